// *** hdl/uart_shadow_data_port.sv ***
/*
  UART shadow data port: sixteen aliased words over AHB-Lite that read the
  receive buffer or FIFO head and write the transmit buffer or FIFO.
  Assumes line decoders deliver whole characters as one-cycle strobes, and
  the line encoder raises its busy input the cycle after a load pulse.
*/
// The address map and the AHB-Lite register port were decided locally.
// Function
// - All sixteen shadow words read the receive side and write the transmit side.
// - Low byte reads the character from the serial or infrared decoder by mode.
// - Read data is valid only while the data-ready flag is set.
// - Without FIFOs a new character overwrites an unread one and flags overrun.
// - With FIFOs a shadow read returns the receive FIFO head.
// - Full receive FIFO keeps contents, drops new character, flags overrun.
// - Written byte goes to serial output or inverted infrared output by mode.
// - Without FIFOs one write clears the transmit-holding-empty flag.
// - With FIFOs sixteen writes are accepted before the transmit FIFO is full.
// - A write to a full transmit FIFO is dropped, contents unchanged.
// - Without FIFOs a further write replaces the pending transmit byte.
module uart_shadow_data_port
  import uart_shadow_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire char_t       serial_rx,
  input  wire char_t       ir_rx,
  input  wire logic        tx_busy,
  output tx_char_t         serial_tx,
  output tx_char_t         ir_tx_n,
  output logic             data_ready,
  output logic             tx_hold_empty,
  output logic             irq
);
  // ==========================================================================
  // Reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;

  // Two flops release the asynchronous reset in step with the clock.
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn) rst_sync_reg <= 2'h0;
    else       rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ==========================================================================
  // Bus decode
  logic [1:0]         ctrl_reg;
  logic               fifo_en;
  logic               ir_mode;
  logic [INT_BITS-1:0] int_status_reg;
  logic [INT_BITS-1:0] int_mask_reg;
  logic               wr_pend_reg;
  logic [7:0]         wr_addr_reg;
  logic               addr_phase;
  logic               rd_req;
  logic [7:0]         a_addr;
  logic               rd_shadow;
  logic               wr_shadow;

  assign fifo_en    = ctrl_reg[CTRL_FIFO_EN_BIT];
  assign ir_mode    = ctrl_reg[CTRL_IR_MODE_BIT];
  assign addr_phase = hsel && htrans[1] && hready;
  assign rd_req     = addr_phase && !hwrite && (haddr[31:8] == 24'h0);
  assign a_addr     = haddr[7:0];
  assign rd_shadow  = rd_req && (haddr[31:8] == 24'h0) && (a_addr <= SHADOW_LAST_ADDR);
  assign wr_shadow  = wr_pend_reg && (wr_addr_reg <= SHADOW_LAST_ADDR);

  // A write address is held for the following data phase.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
    end
    else
    begin
      wr_pend_reg <= addr_phase && hwrite && (haddr[31:8] == 24'h0);
      wr_addr_reg <= {a_addr[7:2], 2'h0};
    end
  end

  // ==========================================================================
  // Receive buffer
  logic [7:0]       rx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] rx_rd_reg, rx_wr_reg;
  logic [CNT_W-1:0] rx_cnt_reg, rx_cnt_next, depth;
  char_t            rx_in;
  logic             rx_pop, rx_can, rx_ovr, ovr_reg, fifo_chg;

  assign depth    = fifo_en ? DEPTH_FIFO : DEPTH_SINGLE;
  assign rx_in    = ir_mode ? ir_rx : serial_rx;
  assign rx_pop   = rd_shadow && (rx_cnt_reg != 5'h00);
  assign rx_can   = (rx_cnt_reg < depth) || rx_pop;
  assign rx_ovr   = rx_in.valid && !rx_can;
  assign fifo_chg = wr_pend_reg && (wr_addr_reg == CTRL_ADDR) &&
                    (hwdata[CTRL_FIFO_EN_BIT] != fifo_en);
  assign rx_cnt_next = rx_cnt_reg + CNT_W'(rx_in.valid && rx_can) - CNT_W'(rx_pop);

  // Pointers and count; changing the FIFO mode flushes both buffers.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_rd_reg  <= '0;
      rx_wr_reg  <= '0;
      rx_cnt_reg <= '0;
    end
    else if (fifo_chg)
    begin
      rx_rd_reg  <= '0;
      rx_wr_reg  <= '0;
      rx_cnt_reg <= '0;
    end
    else
    begin
      if (rx_pop) rx_rd_reg <= rx_rd_reg + 4'h1;
      if (rx_in.valid && rx_can) rx_wr_reg <= rx_wr_reg + 4'h1;
      rx_cnt_reg <= rx_cnt_next;
    end
  end

  // Storage cleared by reset so an early read sees zero; a full single buffer
  // is overwritten, a full FIFO is left alone.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) rx_mem <= '{default: BYTE_RESET};
    else if (rx_in.valid && rx_can) rx_mem[rx_wr_reg] <= rx_in.data;
    else if (rx_ovr && !fifo_en) rx_mem[rx_rd_reg] <= rx_in.data;
  end

  // Overrun stays set until the status word is read.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n) ovr_reg <= 1'b0;
    else if (rx_ovr) ovr_reg <= 1'b1;
    else if (rd_req && a_addr == STATUS_ADDR) ovr_reg <= 1'b0;
  end

  // ==========================================================================
  // Transmit buffer
  logic [7:0]       tx_mem [FIFO_DEPTH];
  logic [PTR_W-1:0] tx_rd_reg, tx_wr_reg;
  logic [CNT_W-1:0] tx_cnt_reg, tx_cnt_next;
  logic             tx_pop, tx_can, tx_drop, tx_over, load_reg;

  assign tx_pop  = (tx_cnt_reg != 5'h00) && !tx_busy && !load_reg;
  assign tx_can  = (tx_cnt_reg < depth) || tx_pop;
  assign tx_over = wr_shadow && !tx_can;
  assign tx_drop = tx_over && fifo_en;
  assign tx_cnt_next = tx_cnt_reg + CNT_W'(wr_shadow && tx_can) - CNT_W'(tx_pop);

  // Pointers and count of pending transmit bytes.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_rd_reg  <= '0;
      tx_wr_reg  <= '0;
      tx_cnt_reg <= '0;
    end
    else if (fifo_chg)
    begin
      tx_rd_reg  <= '0;
      tx_wr_reg  <= '0;
      tx_cnt_reg <= '0;
    end
    else
    begin
      if (tx_pop) tx_rd_reg <= tx_rd_reg + 4'h1;
      if (wr_shadow && tx_can) tx_wr_reg <= tx_wr_reg + 4'h1;
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  // Only the low byte is stored; a single pending byte may be replaced.
  always_ff @(posedge clk)
  begin
    if (wr_shadow && tx_can) tx_mem[tx_wr_reg] <= hwdata[7:0];
    else if (tx_over && !fifo_en) tx_mem[tx_rd_reg] <= hwdata[7:0];
  end

  // The head byte is loaded to the encoder of the selected line.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      load_reg  <= 1'b0;
      serial_tx <= '{load: 1'b0, data: BYTE_RESET};
      ir_tx_n   <= '{load: 1'b0, data: ~BYTE_RESET};
    end
    else
    begin
      load_reg       <= tx_pop;
      serial_tx.load <= tx_pop && !ir_mode;
      ir_tx_n.load   <= tx_pop && ir_mode;
      if (tx_pop)
      begin
        serial_tx.data <= tx_mem[tx_rd_reg];
        ir_tx_n.data   <= ~tx_mem[tx_rd_reg];
      end
    end
  end

  // ==========================================================================
  // Control, flags and interrupt
  logic [INT_BITS-1:0] int_event;
  logic [INT_BITS-1:0] int_status_next;
  logic                tx_empty_rise;

  assign tx_empty_rise = (tx_cnt_reg != 5'h00) && (tx_cnt_next == 5'h00);
  assign int_event = {tx_empty_rise, rx_in.valid && rx_can, tx_drop, rx_ovr};
  assign int_status_next = (int_status_reg &
                            ~((wr_pend_reg && wr_addr_reg == INT_STATUS_ADDR) ?
                              hwdata[INT_BITS-1:0] : INT_RESET)) | int_event;

  // Software writes the control and mask words; events win over clears.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ctrl_reg       <= CTRL_RESET;
      int_mask_reg   <= INT_RESET;
      int_status_reg <= INT_RESET;
      irq            <= 1'b0;
      data_ready     <= 1'b0;
      tx_hold_empty  <= 1'b1;
    end
    else
    begin
      if (wr_pend_reg && wr_addr_reg == CTRL_ADDR) ctrl_reg <= hwdata[1:0];
      if (wr_pend_reg && wr_addr_reg == INT_MASK_ADDR)
        int_mask_reg <= hwdata[INT_BITS-1:0];
      int_status_reg <= int_status_next;
      irq            <= |(int_status_next & int_mask_reg);
      data_ready     <= fifo_chg ? 1'b0 : (rx_cnt_next != 5'h00);
      tx_hold_empty  <= fifo_chg ? 1'b1 : (tx_cnt_next == 5'h00);
    end
  end

  // ==========================================================================
  // Read data and response
  logic [31:0] rd_word;

  // Read word chosen in the address phase and presented in the data phase.
  always_comb
  begin
    rd_word = DATA_RESET;
    if (rd_shadow) rd_word = {24'h0, rx_mem[rx_rd_reg]};
    else if (rd_req && a_addr == CTRL_ADDR) rd_word = {30'h0, ctrl_reg};
    else if (rd_req && a_addr == STATUS_ADDR)
    begin
      rd_word[STAT_DATA_RDY_BIT]  = rx_cnt_reg != 5'h00;
      rd_word[STAT_OVERRUN_BIT]   = ovr_reg;
      rd_word[STAT_TX_EMPTY_BIT]  = tx_cnt_reg == 5'h00;
      rd_word[STAT_RX_CNT_LSB +: CNT_W] = rx_cnt_reg;
      rd_word[STAT_TX_CNT_LSB +: CNT_W] = tx_cnt_reg;
    end
    else if (rd_req && a_addr == INT_STATUS_ADDR) rd_word = {28'h0, int_status_reg};
    else if (rd_req && a_addr == INT_MASK_ADDR) rd_word = {28'h0, int_mask_reg};
  end

  // Zero wait states and an OKAY answer on every transfer.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      hrdata    <= DATA_RESET;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      hrdata    <= rd_word;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  shadow_read_pops_a: assert property (rd_shadow && rx_cnt_reg != 5'h00 && !rx_in.valid
    && !fifo_chg |=> rx_cnt_reg == $past(rx_cnt_reg) - 5'h01)
    else $error("shadow read did not pop receive buffer");
  rx_mode_select_a: assert property (ir_mode && ir_rx.valid && rx_can && !fifo_chg
    |=> rx_mem[$past(rx_wr_reg)] == $past(ir_rx.data))
    else $error("infrared character not stored");
  data_ready_flag_a: assert property (data_ready == (rx_cnt_reg != 5'h00))
    else $error("data ready flag disagrees with receive count");
  single_overwrite_a: assert property (!fifo_en && rx_ovr && !fifo_chg
    |=> ovr_reg && rx_mem[rx_rd_reg] == $past(rx_in.data))
    else $error("single buffer not overwritten on overrun");
  fifo_head_read_a: assert property (rd_shadow |=> hrdata == {24'h0, $past(rx_mem[rx_rd_reg])})
    else $error("read did not return receive head");
  full_fifo_keep_a: assert property (fifo_en && rx_ovr && !fifo_chg
    |=> rx_cnt_reg == DEPTH_FIFO && int_status_reg[INT_OVERRUN_BIT])
    else $error("full receive FIFO changed on overrun");
  ir_out_invert_a: assert property (tx_pop && ir_mode
    |=> ir_tx_n.load && ir_tx_n.data == ~$past(tx_mem[tx_rd_reg]))
    else $error("infrared output not inverted head byte");
  single_write_flag_a: assert property (!fifo_en && wr_shadow && tx_cnt_reg == 5'h00
    && !fifo_chg |=> !tx_hold_empty)
    else $error("write did not clear transmit empty flag");
  tx_depth_limit_a: assert property (tx_cnt_reg <= depth)
    else $error("transmit count above depth");
  full_tx_drop_a: assert property (tx_drop |=> tx_cnt_reg == DEPTH_FIFO
    && tx_wr_reg == $past(tx_wr_reg))
    else $error("write to full transmit FIFO not dropped");
  single_replace_a: assert property (!fifo_en && tx_over && !fifo_chg
    |=> tx_mem[tx_rd_reg] == $past(hwdata[7:0]))
    else $error("pending byte not replaced");
  upper_bits_zero_a: assert property (rd_shadow |=> hrdata[31:8] == 24'h0)
    else $error("reserved bits not zero");

  rx_overrun_c: cover property (rx_ovr && fifo_en);
  tx_fifo_full_c: cover property (tx_drop);
  ir_send_c: cover property (ir_tx_n.load);
  irq_raise_c: cover property ($rose(irq));
endmodule

// *** hdl/uart_shadow_pkg.sv ***
/*
  Constants and carrier types for the UART shadow data port.
  Assumes a 50 MHz single clock and a 32-bit AHB-Lite register bus.
*/
package uart_shadow_pkg;
  // ==========================================================================
  // Register map (byte addresses).
  localparam logic [7:0] SHADOW_FIRST_ADDR = 8'h00;
  localparam logic [7:0] SHADOW_LAST_ADDR  = 8'h3c;
  localparam logic [7:0] CTRL_ADDR         = 8'h40;
  localparam logic [7:0] STATUS_ADDR       = 8'h44;
  localparam logic [7:0] INT_STATUS_ADDR   = 8'h48;
  localparam logic [7:0] INT_MASK_ADDR     = 8'h4c;
  // ==========================================================================
  // Field positions.
  localparam int CTRL_FIFO_EN_BIT   = 0;
  localparam int CTRL_IR_MODE_BIT   = 1;
  localparam int STAT_DATA_RDY_BIT  = 0;
  localparam int STAT_OVERRUN_BIT   = 1;
  localparam int STAT_TX_EMPTY_BIT  = 5;
  localparam int STAT_RX_CNT_LSB    = 8;
  localparam int STAT_TX_CNT_LSB    = 16;
  localparam int INT_OVERRUN_BIT    = 0;
  localparam int INT_TX_DROP_BIT    = 1;
  localparam int INT_RX_DATA_BIT    = 2;
  localparam int INT_TX_EMPTY_BIT   = 3;
  localparam int INT_BITS           = 4;
  // ==========================================================================
  // Sizes and reset values.
  localparam int          FIFO_DEPTH    = 16;
  localparam int          PTR_W         = 4;
  localparam int          CNT_W         = 5;
  localparam logic [4:0]  DEPTH_FIFO    = 5'h10;
  localparam logic [4:0]  DEPTH_SINGLE  = 5'h01;
  localparam logic [1:0]  CTRL_RESET    = 2'h0;
  localparam logic [3:0]  INT_RESET     = 4'h0;
  localparam logic [31:0] DATA_RESET    = 32'h0000_0000;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

  // One received character from a line decoder.
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } char_t;

  // One byte handed to a line encoder.
  typedef struct packed {
    logic       load;
    logic [7:0] data;
  } tx_char_t;
endpackage

// *** testbench/uart_shadow_data_port_bench.sv ***
/*
  Self-checking bench for the UART shadow data port over AHB-Lite.
  Assumes zero-wait slave timing and the partner model on the line side.
*/
`define CHK(got, exp) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) \
    begin \
      fails++; \
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp); \
    end \
  end

module uart_shadow_data_port_bench
  import uart_shadow_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk, rstn, hsel, hwrite, hready, hreadyout, hresp, rd_pend;
  logic        tx_busy, data_ready, tx_hold_empty, irq;
  logic [31:0] haddr, hwdata, hrdata, exp_w;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [7:0]  busy_len, exp_b;
  logic [7:0]  b[0:17];
  char_t       serial_rx, ir_rx;
  tx_char_t    serial_tx, ir_tx_n;
  int          fails, total_checks, seed, n;
  logic [31:0] rd_q[$];
  logic [7:0]  tx_q[$];

  // ==========================================================================
  // Clock, bus loop-back and instances.
  initial clk = 1'b0;
  always #10 clk = ~clk;
  assign hready = hreadyout;

  uart_shadow_data_port i_dut (
    .clk(clk), .rstn(rstn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .serial_rx(serial_rx), .ir_rx(ir_rx), .tx_busy(tx_busy),
    .serial_tx(serial_tx), .ir_tx_n(ir_tx_n), .data_ready(data_ready),
    .tx_hold_empty(tx_hold_empty), .irq(irq)
  );

  uart_line_partner i_partner (
    .clk(clk), .busy_len(busy_len), .serial_tx(serial_tx), .ir_tx_n(ir_tx_n),
    .tx_busy(tx_busy), .serial_rx(serial_rx), .ir_rx(ir_rx)
  );

  // ==========================================================================
  // Watchers: each read data phase and each encoder load takes the oldest note.
  always @(posedge clk)
  begin
    if (rd_pend === 1'b1 && hreadyout === 1'b1)
    begin
      exp_w = rd_q.size() ? rd_q.pop_front() : 32'hxxxx_xxxx;
      `CHK(hrdata, exp_w)
      `CHK(hresp, 1'b0)
    end
    if (serial_tx.load === 1'b1)
    begin
      exp_b = tx_q.size() ? tx_q.pop_front() : 8'hxx;
      `CHK(serial_tx.data, exp_b)
    end
    if (ir_tx_n.load === 1'b1)
    begin
      exp_b = tx_q.size() ? tx_q.pop_front() : 8'hxx;
      `CHK(~ir_tx_n.data, exp_b)
    end
  end

  // ==========================================================================
  // Closing report and bounded waits.
  task automatic final_report();
    if (fails == 0 && total_checks > 0 && rd_q.size() == 0 && tx_q.size() == 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic wait_ready();
    n = 0;
    do @(posedge clk) n++; while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      fails++;
      final_report();
    end
  endtask

  task automatic wait_idle();
    n = 0;
    while ((tx_q.size() != 0 || tx_hold_empty !== 1'b1) && n < 4000)
      @(posedge clk) n++;
    if (n >= 4000)
    begin
      fails++;
      final_report();
    end
  endtask

  // Single AHB-Lite transfer; a read notes its expected word.
  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d,
                     input logic [31:0] e);
    @(posedge clk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= w;
    wait_ready();
    hsel    <= 1'b0;
    htrans  <= 2'h0;
    hwdata  <= d;
    rd_pend <= !w;
    if (!w)
      rd_q.push_back(e);
    wait_ready();
    rd_pend <= 1'b0;
  endtask

  // Byte with random upper bits, which the port must ignore.
  function automatic logic [31:0] word(input logic [7:0] v);
    logic [31:0] r;
    r = $random(seed);
    return {r[31:8], v};
  endfunction

  // ==========================================================================
  // Main sequence.
  initial
  begin
    seed         = 21;
    fails        = 0;
    total_checks = 0;
    rstn         = 1'b0;
    {hsel, hwrite, rd_pend} = 3'h0;
    {haddr, hwdata} = 64'h0;
    htrans       = 2'h0;
    hsize        = 3'h2;
    busy_len     = 8'h28;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    repeat (3) @(posedge clk);
    bus(1'b0, 32'h0000_0000, 32'h0, 32'h0000_0000);
    bus(1'b0, {24'h0, STATUS_ADDR}, 32'h0, 32'h0000_0020);
    bus(1'b0, 32'h0000_0080, 32'h0, 32'h0000_0000);
    // No FIFO: a second write while the encoder is busy replaces the pending byte.
    for (int i = 0; i < 5; i++)
      b[i] = $random(seed);
    tx_q.push_back(b[0]);
    tx_q.push_back(b[2]);
    `CHK(tx_hold_empty, 1'b1)
    bus(1'b1, 32'h0000_0004, word(b[0]), 32'h0);
    bus(1'b1, 32'h0000_0008, word(b[1]), 32'h0);
    bus(1'b0, {24'h0, STATUS_ADDR}, 32'h0, 32'h0001_0000);
    bus(1'b1, 32'h0000_003c, word(b[2]), 32'h0);
    wait_idle();
    // No FIFO receive: an unread byte is overwritten and overrun flagged.
    i_partner.send(1'b0, b[3]);
    i_partner.send(1'b0, b[4]);
    bus(1'b0, {24'h0, STATUS_ADDR}, 32'h0, 32'h0000_0123);
    bus(1'b0, $random(seed) & 32'h3c, 32'h0, {24'h0, b[4]});
    bus(1'b0, {24'h0, STATUS_ADDR}, 32'h0, 32'h0000_0020);
    `CHK(data_ready, 1'b0)
    // Interrupt raised by a masked-in event, then cleared by writing ones.
    bus(1'b1, {24'h0, INT_MASK_ADDR}, 32'h4, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    bus(1'b0, {24'h0, INT_STATUS_ADDR}, 32'h0, 32'h0000_000d);
    bus(1'b1, {24'h0, INT_STATUS_ADDR}, 32'hf, 32'h0);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    bus(1'b1, {24'h0, INT_MASK_ADDR}, 32'h2, 32'h0);
    // FIFO and infrared: the seventeenth character is dropped, order is kept.
    bus(1'b1, {24'h0, CTRL_ADDR}, 32'h3, 32'h0);
    for (int i = 0; i < 17; i++)
    begin
      b[i] = $random(seed);
      i_partner.send(1'b1, b[i]);
    end
    i_partner.send(1'b0, 8'hee);
    bus(1'b0, {24'h0, STATUS_ADDR}, 32'h0, 32'h0000_1023);
    for (int i = 0; i < 16; i++)
      bus(1'b0, 32'(i * 4), 32'h0, {24'h0, b[i]});
    bus(1'b0, {24'h0, STATUS_ADDR}, 32'h0, 32'h0000_0020);
    // FIFO transmit: one in flight, sixteen stored, the next one dropped.
    busy_len <= 8'h50;
    for (int i = 0; i < 18; i++)
    begin
      b[i] = $random(seed);
      if (i < 17)
        tx_q.push_back(b[i]);
      bus(1'b1, 32'((i * 4) % 64), word(b[i]), 32'h0);
    end
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wait_idle();
    repeat (4) @(posedge clk);
    final_report();
  end
endmodule

// *** testbench/uart_shadow_partner.sv ***
/*
  Far-side model of the UART shadow data port: the line decoders that hand
  in received characters and the line encoder that takes loaded bytes.
  Assumes the bench calls send at will and sets busy_len per scenario.
*/
module uart_line_partner
  import uart_shadow_pkg::*;
(
  input  wire logic       clk,
  input  wire logic [7:0] busy_len,
  input  wire tx_char_t   serial_tx,
  input  wire tx_char_t   ir_tx_n,
  output logic            tx_busy,
  output char_t           serial_rx,
  output char_t           ir_rx
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] busy_cnt;

  // ==========================================================================
  // Idle state at time zero.
  initial
  begin
    tx_busy   = 1'b0;
    busy_cnt  = 8'h00;
    serial_rx = {1'b0, 8'h5a};
    ir_rx     = {1'b0, 8'ha5};
  end

  // Encoder raises busy the cycle after a load and holds it busy_len cycles.
  always @(posedge clk)
  begin
    if (serial_tx.load === 1'b1 || ir_tx_n.load === 1'b1)
    begin
      tx_busy  <= 1'b1;
      busy_cnt <= busy_len;
    end
    else if (busy_cnt > 8'h01)
      busy_cnt <= busy_cnt - 8'h01;
    else
    begin
      tx_busy  <= 1'b0;
      busy_cnt <= 8'h00;
    end
  end

  // One-cycle character strobe on the chosen decoder; idle data then flips.
  task automatic send(input logic ir, input logic [7:0] d);
    @(posedge clk);
    ir_rx     <= {ir, ir ? d : ir_rx.data};
    serial_rx <= {!ir, ir ? serial_rx.data : d};
    @(posedge clk);
    ir_rx     <= {1'b0, ~ir_rx.data};
    serial_rx <= {1'b0, ~serial_rx.data};
  endtask
endmodule
